// file: hw/hdf_pkg.sv
/*
 Package for the host data buffer: register map, field positions, depths and the
 register access carrier. Assumes a byte-wide host register port on one clock.
*/
package hdf_pkg;
	localparam int unsigned HDF_ADDR_W = 7;
	localparam int unsigned HDF_DATA_W = 8;
	localparam logic [6:0] HDF_ADDR_CONTROL = 7'h02;
	localparam logic [6:0] HDF_ADDR_THRESHOLD = 7'h03;
	localparam logic [6:0] HDF_ADDR_COUNT = 7'h04;
	localparam logic [6:0] HDF_ADDR_DATA = 7'h05;
	localparam int unsigned HDF_BIT_CAPACITY = 7;
	localparam int unsigned HDF_BIT_NEAR_FULL = 6;
	localparam int unsigned HDF_BIT_NEAR_EMPTY = 5;
	localparam int unsigned HDF_BIT_CLEAR = 4;
	localparam int unsigned HDF_BIT_THR_MSB = 2;
	localparam int unsigned HDF_BIT_CNT_HI = 1;
	localparam int unsigned HDF_BIT_CNT_LO = 0;
	localparam logic [9:0] HDF_DEPTH_SMALL = 10'h0ff;
	localparam logic [9:0] HDF_DEPTH_LARGE = 10'h200;
	localparam int unsigned HDF_MAX_DEPTH = 512;
	localparam int unsigned HDF_STAGE_DEPTH = 16;
	localparam logic [7:0] HDF_RESET_BYTE = 8'h00;
	localparam logic HDF_RESET_CAPACITY = 1'b0;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} hdf_req_s;

	typedef struct packed {
		logic near_full;
		logic near_empty;
		logic write_error;
		logic overflow_error;
	} hdf_evt_s;
endpackage

// file: hw/hdf_top.sv
/*
 Host data buffer: control, threshold, count and data port registers, a large
 byte store, and a 16-word staging FIFO feeding it from the data port.
 Assumes one register access per cycle on the host port, synchronous to i_clock.
*/
`timescale 1ns/100ps

module hdf_stage_fifo
#(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 16
)
(
	input wire logic i_clock,
	input wire logic i_srst,
	input wire logic i_flush,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [WIDTH-1:0] o_out_data
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	assign o_in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt_r != '0);
	assign o_out_data = mem_r[rp_r];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	always_ff @(posedge i_clock)
	begin
		if (push)
			mem_r[wp_r] <= i_in_data;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_srst || i_flush)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= AW'(wp_r + 1'b1);
			if (pop)
				rp_r <= AW'(rp_r + 1'b1);
			if (push && !pop)
				cnt_r <= (AW+1)'(cnt_r + 1'b1);
			else if (pop && !push)
				cnt_r <= (AW+1)'(cnt_r - 1'b1);
		end
	end
endmodule

module hdf_top
	import hdf_pkg::*;
#(
	parameter int unsigned STAGE_DEPTH = hdf_pkg::HDF_STAGE_DEPTH
)
(
	input wire logic i_clock,
	input wire logic i_srst,
	input wire hdf_pkg::hdf_req_s i_req,
	input wire logic i_event_clear,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	output logic o_addr_hold,
	output logic o_near_full_flag,
	output logic o_near_empty_flag,
	output logic o_near_full_event,
	output logic o_near_empty_event,
	output logic o_error_event,
	output logic o_write_error,
	output logic o_overflow_error
);
	import hdf_pkg::*;

	logic [7:0] store_r [HDF_MAX_DEPTH];
	logic [8:0] wp_r;
	logic [8:0] rp_r;
	logic [9:0] count_r;
	logic capacity_select_r;
	logic threshold_msb_r;
	logic [7:0] threshold_r;
	logic near_full_d_r;
	logic near_empty_d_r;
	logic [9:0] depth;
	logic [9:0] level;
	logic [9:0] free_space;
	logic near_full;
	logic near_empty;
	logic data_wr;
	logic data_rd;
	logic ctrl_wr;
	logic buffer_clear;
	logic st_ready;
	logic st_valid;
	logic [7:0] st_data;
	logic drain;
	logic take;
	logic store_full;
	logic [7:0] head_byte;
	hdf_evt_s evt;

	assign data_wr = i_req.wr && (i_req.addr == HDF_ADDR_DATA);
	assign data_rd = i_req.rd && (i_req.addr == HDF_ADDR_DATA);
	assign ctrl_wr = i_req.wr && (i_req.addr == HDF_ADDR_CONTROL);
	assign buffer_clear = ctrl_wr && i_req.wdata[HDF_BIT_CLEAR];

	assign depth = capacity_select_r ? HDF_DEPTH_SMALL : HDF_DEPTH_LARGE;
	// Threshold extension only in large mode
	assign level = {1'b0, (threshold_msb_r && !capacity_select_r), threshold_r};
	assign free_space = 10'(depth - count_r);
	assign near_full = (free_space <= level);
	assign near_empty = (count_r <= level);
	assign store_full = (count_r >= depth);
	assign head_byte = store_r[rp_r];

	// Staging FIFO feeds the store; stalls while the store is full
	hdf_stage_fifo #(.WIDTH(HDF_DATA_W), .DEPTH(STAGE_DEPTH)) u_stage
	(
		.i_clock(i_clock),
		.i_srst(i_srst),
		.i_flush(buffer_clear),
		.i_in_valid(data_wr),
		.o_in_ready(st_ready),
		.i_in_data(i_req.wdata),
		.o_out_valid(st_valid),
		.i_out_ready(!store_full),
		.o_out_data(st_data)
	);
	assign drain = st_valid && !store_full;
	assign take = data_rd && (count_r != '0);

	always_ff @(posedge i_clock)
	begin
		if (drain)
			store_r[wp_r] <= st_data;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_srst || buffer_clear)
		begin
			wp_r <= '0;
			rp_r <= '0;
			count_r <= '0;
		end
		else
		begin
			if (drain)
				wp_r <= (wp_r == 9'(depth - 10'h001)) ? '0 : 9'(wp_r + 1'b1);
			if (take)
				rp_r <= (rp_r == 9'(depth - 10'h001)) ? '0 : 9'(rp_r + 1'b1);
			if (drain && !take)
				count_r <= 10'(count_r + 1'b1);
			else if (take && !drain)
				count_r <= 10'(count_r - 1'b1);
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			capacity_select_r <= HDF_RESET_CAPACITY;
			threshold_msb_r <= 1'b0;
			threshold_r <= HDF_RESET_BYTE;
		end
		else
		begin
			if (ctrl_wr)
			begin
				capacity_select_r <= i_req.wdata[HDF_BIT_CAPACITY];
				threshold_msb_r <= i_req.wdata[HDF_BIT_THR_MSB];
			end
			if (i_req.wr && (i_req.addr == HDF_ADDR_THRESHOLD))
				threshold_r <= i_req.wdata;
		end
	end

	// Read data path
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			o_rdata <= HDF_RESET_BYTE;
			o_rvalid <= 1'b0;
			o_addr_hold <= 1'b0;
		end
		else
		begin
			o_rvalid <= i_req.rd;
			o_addr_hold <= (i_req.rd || i_req.wr) && (i_req.addr == HDF_ADDR_DATA);
			o_rdata <= HDF_RESET_BYTE;
			if (i_req.rd)
			begin
				case (i_req.addr)
					HDF_ADDR_CONTROL:
					begin
						o_rdata[HDF_BIT_CAPACITY] <= capacity_select_r;
						o_rdata[HDF_BIT_NEAR_FULL] <= near_full;
						o_rdata[HDF_BIT_NEAR_EMPTY] <= near_empty;
						o_rdata[HDF_BIT_THR_MSB] <= threshold_msb_r;
						o_rdata[HDF_BIT_CNT_HI] <= count_r[9] && !capacity_select_r;
						o_rdata[HDF_BIT_CNT_LO] <= count_r[8] && !capacity_select_r;
					end
					HDF_ADDR_THRESHOLD: o_rdata <= threshold_r;
					HDF_ADDR_COUNT: o_rdata <= count_r[7:0];
					HDF_ADDR_DATA: o_rdata <= take ? head_byte : HDF_RESET_BYTE;
					default: o_rdata <= HDF_RESET_BYTE;
				endcase
			end
		end
	end

	assign evt.near_full = near_full && !near_full_d_r;
	assign evt.near_empty = near_empty && !near_empty_d_r;
	assign evt.write_error = data_wr && !st_ready;
	assign evt.overflow_error = drain && (count_r == 10'(depth - 10'h001)) && data_wr;

	// Flags and sticky events; a new event wins over a clear
	always_ff @(posedge i_clock)
	begin
		if (i_srst)
		begin
			near_full_d_r <= 1'b0;
			near_empty_d_r <= 1'b0;
			o_near_full_flag <= 1'b0;
			o_near_empty_flag <= 1'b0;
			o_near_full_event <= 1'b0;
			o_near_empty_event <= 1'b0;
			o_error_event <= 1'b0;
			o_write_error <= 1'b0;
			o_overflow_error <= 1'b0;
		end
		else
		begin
			near_full_d_r <= near_full;
			near_empty_d_r <= near_empty;
			o_near_full_flag <= near_full;
			o_near_empty_flag <= near_empty;
			o_near_full_event <= evt.near_full || (o_near_full_event && !i_event_clear);
			o_near_empty_event <= evt.near_empty || (o_near_empty_event && !i_event_clear);
			o_write_error <= evt.write_error || (o_write_error && !i_event_clear);
			o_overflow_error <= evt.overflow_error || (o_overflow_error && !i_event_clear);
			o_error_event <= evt.write_error || evt.overflow_error || (o_error_event && !i_event_clear);
		end
	end
endmodule

// file: tb/hdf_checker.sv
/*
 Port checker for hdf_top.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module hdf_checker
	import hdf_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_srst,
	input wire hdf_pkg::hdf_req_s i_req,
	input wire logic i_event_clear,
	input wire logic [7:0] o_rdata,
	input wire logic o_rvalid,
	input wire logic o_addr_hold,
	input wire logic o_near_full_flag,
	input wire logic o_near_empty_flag,
	input wire logic o_near_full_event,
	input wire logic o_near_empty_event,
	input wire logic o_error_event,
	input wire logic o_write_error,
	input wire logic o_overflow_error
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_srst);
	wire acc = i_req.wr | i_req.rd;
	wire dat = acc && i_req.addr == HDF_ADDR_DATA;
	property p_rvalid;
		i_req.rd |=> o_rvalid;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	property p_hold;
		dat |=> o_addr_hold;
	endproperty
	a_hold: assert property (p_hold) else $error("pointer hold missing");
	property p_nohold;
		!dat |=> !o_addr_hold;
	endproperty
	a_nohold: assert property (p_nohold) else $error("pointer held wrongly");
	property p_clrbit;
		i_req.rd && i_req.addr == HDF_ADDR_CONTROL |=> o_rvalid && !o_rdata[HDF_BIT_CLEAR];
	endproperty
	a_clrbit: assert property (p_clrbit) else $error("clear bit read as one");
	property p_nf_evt;
		$rose(o_near_full_flag) |-> ##[0:1] o_near_full_event;
	endproperty
	a_nf_evt: assert property (p_nf_evt) else $error("near full event missing");
	property p_ne_evt;
		$rose(o_near_empty_flag) |-> ##[0:1] o_near_empty_event;
	endproperty
	a_ne_evt: assert property (p_ne_evt) else $error("near empty event missing");
	property p_evt_keep;
		o_near_empty_event && !i_event_clear |=> o_near_empty_event;
	endproperty
	a_evt_keep: assert property (p_evt_keep) else $error("event lost");
	property p_err;
		$rose(o_write_error) || $rose(o_overflow_error) |-> ##[0:1] o_error_event;
	endproperty
	a_err: assert property (p_err) else $error("error event missing");
	c_full: cover property (o_near_full_flag);
	c_werr: cover property ($rose(o_write_error));
	c_read: cover property (o_rvalid && o_addr_hold);
	c_ovf: cover property ($rose(o_overflow_error));
endmodule
bind hdf_top hdf_checker u_chk (.i_clock(i_clock), .i_srst(i_srst), .i_req(i_req),
	.i_event_clear(i_event_clear), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_addr_hold(o_addr_hold),
	.o_near_full_flag(o_near_full_flag), .o_near_empty_flag(o_near_empty_flag),
	.o_near_full_event(o_near_full_event), .o_near_empty_event(o_near_empty_event),
	.o_error_event(o_error_event), .o_write_error(o_write_error), .o_overflow_error(o_overflow_error));

// file: tb/testbench.sv
/*
 Self-checking bench for hdf_top: random bytes, both capacities, clear, errors.
 Assumes the register map of hdf_pkg.
*/
`timescale 1ns/100ps
module testbench;
	import hdf_pkg::*;
	logic i_clock, i_srst, i_event_clear, cap_m, msb_m;
	hdf_req_s i_req;
	logic [7:0] o_rdata, thr_m, v;
	logic o_rvalid, o_addr_hold, o_nff, o_nef, o_nfe, o_nee, o_ee, o_we, o_oe;
	logic [7:0] q[$];
	int bad_count, checks, n;
	hdf_top uut (.i_clock(i_clock), .i_srst(i_srst), .i_req(i_req), .i_event_clear(i_event_clear),
		.o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_addr_hold(o_addr_hold), .o_near_full_flag(o_nff),
		.o_near_empty_flag(o_nef), .o_near_full_event(o_nfe), .o_near_empty_event(o_nee),
		.o_error_event(o_ee), .o_write_error(o_we), .o_overflow_error(o_oe));
	initial
	begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end
	task stop_test;
		$display("Counts: %0d checks, %0d mismatches", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task acc(input logic w, input logic [6:0] a, input logic [7:0] d);
		i_req <= '{w, !w, a, d};
		@(posedge i_clock);
	endtask
	task idle(input int c);
		i_req <= '0;
		repeat (c) @(posedge i_clock);
	endtask
	task rchk(input string nm, input logic [6:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		i_req <= '0;
		#1;
		chk(nm, e, o_rdata);
		@(posedge i_clock);
	endtask
	task evclr;
		i_event_clear <= 1'b1;
		@(posedge i_clock);
		i_event_clear <= 1'b0;
		idle(2);
	endtask
	// Flag and event pins, looked at mid-cycle where they are settled
	task fchk(input string nm, input logic [7:0] e);
		@(negedge i_clock);
		chk(nm, e, {1'b0, o_nff, o_nef, o_oe, o_we, o_ee, o_nfe, o_nee});
		@(posedge i_clock);
	endtask
	// Expected control byte from the model state
	function automatic logic [7:0] ctl_exp(input logic [9:0] c);
		logic [9:0] dep, lvl;
		dep = cap_m ? HDF_DEPTH_SMALL : HDF_DEPTH_LARGE;
		lvl = {1'b0, msb_m & !cap_m, thr_m};
		return {cap_m, (dep - c) <= lvl, c <= lvl, 2'b00, msb_m, cap_m ? 2'b00 : c[9:8]};
	endfunction
	task state;
		rchk("count", HDF_ADDR_COUNT, 8'(q.size()));
		rchk("control", HDF_ADDR_CONTROL, ctl_exp(10'(q.size())));
	endtask
	task ctrl(input logic [7:0] d, input logic [7:0] t);
		cap_m = d[7];
		msb_m = d[2];
		thr_m = t;
		if (d[4])
			q.delete();
		acc(1'b1, HDF_ADDR_CONTROL, d);
		acc(1'b1, HDF_ADDR_THRESHOLD, t);
		idle(3);
	endtask
	task push(input int k);
		repeat (k)
		begin
			v = 8'($urandom);
			q.push_back(v);
			acc(1'b1, HDF_ADDR_DATA, v);
		end
		idle(4);
	endtask
	initial
	begin
		n = $urandom(32'h90f09fdf);
		i_srst = 1'b1;
		i_req = '0;
		i_event_clear = 1'b0;
		{cap_m, msb_m, thr_m} = '0;
		repeat (8) @(posedge i_clock);
		i_srst <= 1'b0;
		idle(3);
		state;
		rchk("threshold", HDF_ADDR_THRESHOLD, 8'h00);
		fchk("flags", 8'h21);
		ctrl(8'h00, 8'($urandom));
		rchk("threshold", HDF_ADDR_THRESHOLD, thr_m);
		$display("test reset done");
		ctrl(8'h14, 8'h30);
		push(300);
		state;
		while (q.size() > 0)
			rchk("data", HDF_ADDR_DATA, q.pop_front());
		state;
		rchk("empty", HDF_ADDR_DATA, 8'h00);
		rchk("unmapped", 7'h7e, 8'h00);
		$display("test order done");
		ctrl(8'h94, 8'h03);
		evclr;
		fchk("flags", 8'h20);
		push(252);
		state;
		fchk("nf_event", 8'h42);
		// Three bytes fill the store, the rest meet a full path
		for (int i = 0; i < 23; i++)
		begin
			v = 8'($urandom);
			if (i < 3)
				q.push_back(v);
			acc(1'b1, HDF_ADDR_DATA, v);
		end
		idle(4);
		state;
		fchk("errors", 8'h5e);
		$display("test small done");
		ctrl(8'h10, 8'h03);
		state;
		evclr;
		fchk("events", 8'h20);
		$display("test clear done");
		stop_test;
	end
	initial
	begin
		#(20000 * 25);
		bad_count++;
		stop_test;
	end
endmodule
